//--- hw/ushd_top.sv
// Shadow receive/transmit data port of the second UART, Avalon-MM slave
`timescale 1ns/1ps

module ushd_top (
	input  wire logic                 I_SYS_CLK,
	input  wire logic                 I_RST,
	input  wire logic                 I_CE,
	input  wire logic [31:0]          I_AVS_ADDRESS,
	input  wire logic                 I_AVS_READ,
	input  wire logic                 I_AVS_WRITE,
	input  wire logic [31:0]          I_AVS_WRITEDATA,
	input  wire logic [3:0]           I_AVS_BYTEENABLE,
	output logic      [31:0]          O_AVS_READDATA,
	output logic                      O_AVS_WAITREQUEST,
	input  wire ushd_pkg::ushd_byte_s I_SER_RX,
	input  wire ushd_pkg::ushd_byte_s I_IR_RX,
	input  wire logic                 I_TX_BUSY,
	output logic      [7:0]           O_TX_BYTE,
	output logic                      O_SER_TX_LOAD,
	output logic                      O_IR_TX_LOAD_N,
	output logic                      O_IRQ
);

	// Address decode shared by the read and write paths
	function automatic logic is_shadow(input logic [31:0] addr);
		logic [31:0] off;
		off = addr - ushd_pkg::SHADOW_BASE_ADDR;
		is_shadow = (addr >= ushd_pkg::SHADOW_BASE_ADDR) && (off < ushd_pkg::SHADOW_SPAN)
			&& (addr[1:0] == 2'h0);
	endfunction

	ushd_pkg::ushd_bus_e bus_st;
	logic [1:0]          ctrl;
	logic                fifo_en;
	logic                ir_mode;
	logic                take;
	logic                take_rd;
	logic                take_wr;
	logic                lane0;
	logic                ctrl_wr;

	logic [7:0]          rx_mem [ushd_pkg::FIFO_DEPTH];
	logic [3:0]          rx_wr_ptr;
	logic [3:0]          rx_rd_ptr;
	logic [4:0]          rx_count;
	logic                rx_overrun;
	ushd_pkg::ushd_byte_s rx_in;
	logic                rx_pop;
	logic                rx_push;
	logic                rx_replace;
	logic                rx_lost;

	logic [7:0]          tx_mem [ushd_pkg::FIFO_DEPTH];
	logic [3:0]          tx_wr_ptr;
	logic [3:0]          tx_rd_ptr;
	logic [4:0]          tx_count;
	logic                tx_empty;
	logic                tx_wr;
	logic                tx_push;
	logic                tx_replace;
	logic                tx_pop;

	logic [2:0]          int_status;
	logic [2:0]          int_enable;
	logic [2:0]          int_event;
	logic                ls_read;
	logic [31:0]         next_readdata;

	assign fifo_en = ctrl[ushd_pkg::CTRL_FIFO_EN_BIT];
	assign ir_mode = ctrl[ushd_pkg::CTRL_IR_MODE_BIT];
	assign lane0   = I_AVS_BYTEENABLE[0];

	// Bus answer: one wait cycle, then the answer cycle with waitrequest low
	assign take              = I_CE && (I_AVS_READ || I_AVS_WRITE) && (bus_st == ushd_pkg::BUS_IDLE);
	assign take_rd           = take && I_AVS_READ;
	assign take_wr           = take && I_AVS_WRITE && lane0;
	assign ctrl_wr           = take_wr && (I_AVS_ADDRESS == ushd_pkg::CTRL_ADDR);
	assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && (bus_st != ushd_pkg::BUS_ANSWER);

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			bus_st <= ushd_pkg::BUS_IDLE;
		end else if (I_CE) begin
			case (bus_st)
				ushd_pkg::BUS_IDLE: begin
					if (I_AVS_READ || I_AVS_WRITE) begin
						bus_st <= ushd_pkg::BUS_ANSWER;
					end
				end
				ushd_pkg::BUS_ANSWER: begin
					bus_st <= ushd_pkg::BUS_IDLE;
				end
				default: begin
					bus_st <= ushd_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// Control register; every write to it flushes both queues
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			ctrl <= ushd_pkg::CTRL_RESET;
		end else if (take_wr && I_AVS_ADDRESS == ushd_pkg::CTRL_ADDR) begin
			ctrl <= I_AVS_WRITEDATA[1:0];
		end
	end

	// Receive path
	assign rx_in      = ir_mode ? I_IR_RX : I_SER_RX;
	assign rx_pop     = take_rd && is_shadow(I_AVS_ADDRESS) && (rx_count != 5'h00);
	assign rx_push    = I_CE && rx_in.valid && (fifo_en ? (rx_count != ushd_pkg::FIFO_FULL || rx_pop)
		: (rx_count == 5'h00 || rx_pop));
	assign rx_replace = I_CE && rx_in.valid && !fifo_en && (rx_count != 5'h00) && !rx_pop;
	assign rx_lost    = I_CE && rx_in.valid && fifo_en && (rx_count == ushd_pkg::FIFO_FULL)
		&& !rx_pop;

	always_ff @(posedge I_SYS_CLK) begin
		if (rx_push) begin
			rx_mem[rx_wr_ptr] <= rx_in.data;
		end else if (rx_replace) begin
			rx_mem[rx_rd_ptr] <= rx_in.data;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || (take_wr && I_AVS_ADDRESS == ushd_pkg::CTRL_ADDR)) begin
			rx_wr_ptr <= 4'h0;
			rx_rd_ptr <= 4'h0;
			rx_count  <= 5'h00;
		end else begin
			if (rx_push) begin
				rx_wr_ptr <= rx_wr_ptr + 4'h1;
			end
			if (rx_pop) begin
				rx_rd_ptr <= rx_rd_ptr + 4'h1;
			end
			if (rx_push && !rx_pop) begin
				rx_count <= rx_count + 5'h01;
			end else if (rx_pop && !rx_push) begin
				rx_count <= rx_count - 5'h01;
			end
		end
	end

	// Overrun is sticky until line status is read; a new loss wins over the clear
	assign ls_read = take_rd && I_AVS_ADDRESS == ushd_pkg::LINE_STATUS_ADDR;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			rx_overrun <= 1'b0;
		end else if (rx_replace || rx_lost) begin
			rx_overrun <= 1'b1;
		end else if (ls_read) begin
			rx_overrun <= 1'b0;
		end
	end

	// Transmit path
	assign tx_empty   = (tx_count == 5'h00);
	assign tx_wr      = take_wr && is_shadow(I_AVS_ADDRESS);
	assign tx_pop     = I_CE && !I_TX_BUSY && !tx_empty;
	assign tx_push    = tx_wr && (fifo_en ? (tx_count != ushd_pkg::FIFO_FULL) : tx_empty);
	assign tx_replace = tx_wr && !fifo_en && !tx_empty && !tx_pop;

	always_ff @(posedge I_SYS_CLK) begin
		if (tx_push) begin
			tx_mem[tx_wr_ptr] <= I_AVS_WRITEDATA[7:0];
		end else if (tx_replace) begin
			tx_mem[tx_rd_ptr] <= I_AVS_WRITEDATA[7:0];
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || (take_wr && I_AVS_ADDRESS == ushd_pkg::CTRL_ADDR)) begin
			tx_wr_ptr <= 4'h0;
			tx_rd_ptr <= 4'h0;
			tx_count  <= 5'h00;
		end else begin
			if (tx_push) begin
				tx_wr_ptr <= tx_wr_ptr + 4'h1;
			end
			if (tx_pop) begin
				tx_rd_ptr <= tx_rd_ptr + 4'h1;
			end
			if (tx_push && !tx_pop) begin
				tx_count <= tx_count + 5'h01;
			end else if (tx_pop && !tx_push) begin
				tx_count <= tx_count - 5'h01;
			end
		end
	end

	// Hand-off to the line engine; the infrared strobe is active low
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			O_TX_BYTE      <= ushd_pkg::DATA_RESET;
			O_SER_TX_LOAD  <= 1'b0;
			O_IR_TX_LOAD_N <= 1'b1;
		end else if (I_CE) begin
			O_SER_TX_LOAD  <= tx_pop && !ir_mode;
			O_IR_TX_LOAD_N <= !(tx_pop && ir_mode);
			if (tx_pop) begin
				O_TX_BYTE <= tx_mem[tx_rd_ptr];
			end
		end
	end

	// Interrupts: sticky status, write-one-to-clear, set wins
	assign int_event[ushd_pkg::INT_RX_BIT]       = rx_push;
	assign int_event[ushd_pkg::INT_OVERRUN_BIT]  = rx_replace || rx_lost;
	assign int_event[ushd_pkg::INT_TX_EMPTY_BIT] = tx_pop && (tx_count == 5'h01) && !tx_push;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			int_status <= ushd_pkg::INT_RESET;
		end else if (take_wr && I_AVS_ADDRESS == ushd_pkg::INT_CLEAR_ADDR) begin
			int_status <= (int_status & ~I_AVS_WRITEDATA[2:0]) | int_event;
		end else begin
			int_status <= int_status | int_event;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			int_enable <= ushd_pkg::INT_RESET;
		end else if (take_wr && I_AVS_ADDRESS == ushd_pkg::INT_ENABLE_ADDR) begin
			int_enable <= I_AVS_WRITEDATA[2:0];
		end
	end

	assign O_IRQ = |(int_status & int_enable);

	// Read mux; unmapped addresses answer zero so a stray read cannot hang the bus
	always_comb begin
		next_readdata = 32'h00000000;
		if (is_shadow(I_AVS_ADDRESS)) begin
			if (rx_count != 5'h00) begin
				next_readdata[7:0] = rx_mem[rx_rd_ptr];
			end
		end else if (I_AVS_ADDRESS == ushd_pkg::CTRL_ADDR) begin
			next_readdata[1:0] = ctrl;
		end else if (I_AVS_ADDRESS == ushd_pkg::LINE_STATUS_ADDR) begin
			next_readdata[ushd_pkg::LS_RX_VALID_BIT] = (rx_count != 5'h00);
			next_readdata[ushd_pkg::LS_OVERRUN_BIT]  = rx_overrun;
			next_readdata[ushd_pkg::LS_TX_EMPTY_BIT] = tx_empty;
		end else if (I_AVS_ADDRESS == ushd_pkg::INT_STATUS_ADDR) begin
			next_readdata[2:0] = int_status;
		end else if (I_AVS_ADDRESS == ushd_pkg::INT_ENABLE_ADDR) begin
			next_readdata[2:0] = int_enable;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			O_AVS_READDATA <= 32'h00000000;
		end else if (take_rd) begin
			O_AVS_READDATA <= next_readdata;
		end
	end

	// Checks
	// Queue checks leave out the flush that a control write causes in the same cycle
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);

	chk_bus_wait_first: assert property (
		(I_AVS_READ && bus_st == ushd_pkg::BUS_IDLE) |-> O_AVS_WAITREQUEST ##1
		(!I_CE || !O_AVS_WAITREQUEST))
		else $error("Read not answered after one wait cycle");

	chk_upper_zero: assert property (
		take_rd && is_shadow(I_AVS_ADDRESS) |=> O_AVS_READDATA[31:8] == 24'h000000)
		else $error("Shadow read shows nonzero upper bits");

	chk_rx_head_pop: assert property (
		rx_pop && !rx_push && fifo_en |=> rx_count == $past(rx_count) - 5'h01)
		else $error("Shadow read did not pop the receive FIFO");

	chk_rx_full_drop: assert property (
		fifo_en && rx_count == ushd_pkg::FIFO_FULL && rx_in.valid && I_CE && !rx_pop
		&& !ctrl_wr
		|=> rx_count == ushd_pkg::FIFO_FULL && rx_overrun && rx_rd_ptr == $past(rx_rd_ptr))
		else $error("Full receive FIFO changed or missed overrun");

	chk_rx_overwrite: assert property (
		!fifo_en && rx_count == 5'h01 && rx_in.valid && I_CE && !rx_pop && !ctrl_wr
		|=> rx_count == 5'h01 && rx_overrun && rx_mem[rx_rd_ptr] == $past(rx_in.data))
		else $error("Unread byte not overwritten with overrun");

	chk_ir_source: assert property (
		ir_mode && I_CE && !I_IR_RX.valid && I_SER_RX.valid && !rx_pop && !ctrl_wr
		|=> rx_count == $past(rx_count))
		else $error("Serial byte taken in infrared mode");

	chk_tx_hold_empty_flag_clear: assert property (
		!fifo_en && tx_empty && tx_wr |=> !tx_empty)
		else $error("Transmit empty still set after write");

	chk_tx_full_drop: assert property (
		fifo_en && tx_count == ushd_pkg::FIFO_FULL && tx_wr && !tx_pop
		|=> tx_count == ushd_pkg::FIFO_FULL && tx_wr_ptr == $past(tx_wr_ptr))
		else $error("Write to full transmit FIFO was queued");

	chk_tx_line_select: assert property (
		tx_pop && ir_mode |=> !O_IR_TX_LOAD_N && !O_SER_TX_LOAD
		&& O_TX_BYTE == $past(tx_mem[tx_rd_ptr]))
		else $error("Infrared send used the wrong output");

	chk_irq_overrun: assert property (
		(rx_replace || rx_lost) && int_enable[ushd_pkg::INT_OVERRUN_BIT] |=> O_IRQ)
		else $error("Overrun did not raise the interrupt");

	chk_tx_hold_replace: assert property (
		tx_replace |=> tx_count == $past(tx_count) && tx_mem[tx_rd_ptr] == $past(I_AVS_WRITEDATA[7:0]))
		else $error("Pending transmit byte was not replaced");

	chk_ser_send: assert property (
		tx_pop && !ir_mode |=> O_SER_TX_LOAD && O_IR_TX_LOAD_N
		&& O_TX_BYTE == $past(tx_mem[tx_rd_ptr]))
		else $error("Serial send used the wrong output");

	chk_empty_read: assert property (
		take_rd && is_shadow(I_AVS_ADDRESS) && rx_count == 5'h00
		|=> O_AVS_READDATA == 32'h00000000)
		else $error("Read of an empty receive buffer was not zero");

	cov_rx_fifo_full: cover property (fifo_en && rx_count == ushd_pkg::FIFO_FULL && rx_lost);
	cov_rx_overwrite: cover property (rx_replace);
	cov_tx_replace:   cover property (tx_replace);
	cov_ir_send:      cover property (!O_IR_TX_LOAD_N);
	cov_tx_fifo_full: cover property (fifo_en && tx_count == ushd_pkg::FIFO_FULL && tx_wr);

endmodule

//--- hw/ushd_pkg.sv
// Package for the second UART shadow data port: map, fields, types
package ushd_pkg;

	// Register map, byte addresses on a 32-bit Avalon-MM slave
	localparam logic [31:0] SHADOW_BASE_ADDR  = 32'h50001130;
	localparam logic [31:0] SHADOW_13_ADDR    = 32'h50001164;
	localparam logic [31:0] CTRL_ADDR         = 32'h50001180;
	localparam logic [31:0] LINE_STATUS_ADDR  = 32'h50001184;
	localparam logic [31:0] INT_STATUS_ADDR   = 32'h50001188;
	localparam logic [31:0] INT_CLEAR_ADDR    = 32'h5000118c;
	localparam logic [31:0] INT_ENABLE_ADDR   = 32'h50001190;
	localparam int          SHADOW_COUNT      = 16;
	localparam logic [31:0] SHADOW_SPAN       = 32'h00000040;

	// Control register fields
	localparam int CTRL_FIFO_EN_BIT  = 0;
	localparam int CTRL_IR_MODE_BIT  = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// Line status fields
	localparam int LS_RX_VALID_BIT   = 0;
	localparam int LS_OVERRUN_BIT    = 1;
	localparam int LS_TX_EMPTY_BIT   = 5;

	// Interrupt status, clear and enable layout
	localparam int INT_RX_BIT        = 0;
	localparam int INT_OVERRUN_BIT   = 1;
	localparam int INT_TX_EMPTY_BIT  = 2;
	localparam int INT_WIDTH         = 3;
	localparam logic [2:0] INT_RESET = 3'h0;

	// Data field and FIFOs
	localparam int DATA_WIDTH        = 8;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int FIFO_DEPTH        = 16;
	localparam int PTR_WIDTH         = 4;
	localparam int CNT_WIDTH         = 5;
	localparam logic [4:0] FIFO_FULL = 5'h10;

	// Byte handed over by the serial or infrared receiver
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} ushd_byte_s;

	// Bus answer sequence
	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b01,
		BUS_ANSWER = 2'b10
	} ushd_bus_e;

endpackage

//--- bench/ushd_line_model.sv
// Line-side model: feeds received bytes, takes transmit hand-offs
`timescale 1ns/1ps
module ushd_line_model (
	input  wire logic            i_clk,
	input  wire logic            i_stall,
	input  wire logic [7:0]      i_tx_byte,
	input  wire logic            i_ser_load,
	input  wire logic            i_ir_load_n,
	output ushd_pkg::ushd_byte_s o_ser_rx,
	output ushd_pkg::ushd_byte_s o_ir_rx,
	output logic                 o_busy
);
	logic [8:0] got[$];
	initial begin
		o_ser_rx = '0;
		o_ir_rx = '0;
	end
	// Busy only while stalled, so hand-offs may come every cycle
	assign o_busy = i_stall;
	always @(posedge i_clk) begin
		if (i_ser_load || !i_ir_load_n) begin
			got.push_back({!i_ir_load_n, i_tx_byte});
		end
	end
	// Idle data is inverted so a stale byte never looks fresh
	task automatic send(input logic [7:0] b, input logic ir);
		@(posedge i_clk);
		if (ir) begin
			o_ir_rx <= {1'b1, b};
		end else begin
			o_ser_rx <= {1'b1, b};
		end
		@(posedge i_clk);
		o_ir_rx <= {1'b0, ~b};
		o_ser_rx <= {1'b0, ~b};
	endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the shadow data port
`timescale 1ns/1ps
module testbench;
	localparam logic [31:0] sh13 = ushd_pkg::SHADOW_13_ADDR;
	localparam logic [31:0] base = ushd_pkg::SHADOW_BASE_ADDR;
	localparam logic [31:0] ls_a = ushd_pkg::LINE_STATUS_ADDR;
	localparam logic [31:0] ist_a = ushd_pkg::INT_STATUS_ADDR;
	localparam logic [31:0] icl_a = ushd_pkg::INT_CLEAR_ADDR;
	localparam logic [31:0] ien_a = ushd_pkg::INT_ENABLE_ADDR;
	logic                 clk;
	logic                 rst;
	logic                 ce;
	logic [31:0]          addr;
	logic                 rd;
	logic                 wr;
	logic [31:0]          wdata;
	logic [31:0]          rdata;
	logic                 waitreq;
	ushd_pkg::ushd_byte_s ser_rx;
	ushd_pkg::ushd_byte_s ir_rx;
	logic                 busy;
	logic                 stall;
	logic [7:0]           tx_byte;
	logic                 ser_load;
	logic                 ir_load_n;
	logic                 irq;
	logic [31:0]          rv;
	int                   error_cnt;
	int                   checks_done;

	ushd_top ushd_top_i (.I_SYS_CLK(clk), .I_RST(rst), .I_CE(ce), .I_AVS_ADDRESS(addr),
		.I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hf),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .I_SER_RX(ser_rx),
		.I_IR_RX(ir_rx), .I_TX_BUSY(busy), .O_TX_BYTE(tx_byte), .O_SER_TX_LOAD(ser_load),
		.O_IR_TX_LOAD_N(ir_load_n), .O_IRQ(irq));
	ushd_line_model ushd_line_model_i (.i_clk(clk), .i_stall(stall), .i_tx_byte(tx_byte),
		.i_ser_load(ser_load), .i_ir_load_n(ir_load_n), .o_ser_rx(ser_rx), .o_ir_rx(ir_rx),
		.o_busy(busy));

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			report_and_stop();
		end
		rv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(what, exp, rv);
	endtask
	task automatic t_reset();
		rd_chk("data reset", sh13, 32'h0);
		rd_chk("status reset", ls_a, 32'h20);
	endtask
	task automatic t_rx_plain();
		bus(1'b1, ien_a, 32'h2);
		ushd_line_model_i.send(8'h5a, 1'b0);
		ushd_line_model_i.send(8'ha5, 1'b0);
		rd_chk("overrun", ls_a, 32'h23);
		check("overrun irq", 32'h1, 32'(irq));
		rd_chk("overrun int status", ist_a, 32'h3);
		rd_chk("rx byte", sh13, 32'ha5);
		rd_chk("rx drained", ls_a, 32'h20);
	endtask
	task automatic t_rx_fifo();
		bus(1'b1, ushd_pkg::CTRL_ADDR, 32'h3);
		ushd_line_model_i.send(8'h77, 1'b0);
		for (int i = 0; i < 17; i++) begin
			ushd_line_model_i.send(8'h40 + 8'(i), 1'b1);
		end
		rd_chk("full overrun", ls_a, 32'h23);
		for (int i = 0; i < 16; i++) begin
			rd_chk("fifo head", base + 32'(4 * i), 32'h40 + 32'(i));
		end
		rd_chk("fifo empty", sh13, 32'h0);
	endtask
	task automatic t_tx_fifo();
		rd_chk("tx empty first", ls_a, 32'h20);
		ushd_line_model_i.got.delete();
		stall <= 1'b1;
		for (int i = 0; i < 17; i++) begin
			bus(1'b1, base + 32'(4 * (i % 16)), 32'hffffff80 + 32'(i));
		end
		rd_chk("tx not empty", ls_a, 32'h0);
		stall <= 1'b0;
		repeat (40) @(posedge clk);
		check("tx count", 32'd16, 32'(ushd_line_model_i.got.size()));
		for (int i = 0; i < 16; i++) begin
			check("tx ir byte", 32'h180 + 32'(i), 32'(ushd_line_model_i.got[i]));
		end
	endtask
	task automatic t_tx_plain();
		bus(1'b1, ushd_pkg::CTRL_ADDR, 32'h0);
		ushd_line_model_i.got.delete();
		stall <= 1'b1;
		bus(1'b1, sh13, 32'h11);
		rd_chk("empty cleared", ls_a, 32'h0);
		bus(1'b1, sh13, 32'h22);
		stall <= 1'b0;
		repeat (10) @(posedge clk);
		check("tx count", 32'd1, 32'(ushd_line_model_i.got.size()));
		check("tx ser byte", 32'h22, 32'(ushd_line_model_i.got[0]));
		rd_chk("empty again", ls_a, 32'h20);
	endtask
	task automatic t_irq();
		bus(1'b1, icl_a, 32'h7);
		bus(1'b1, ien_a, 32'h1);
		check("irq idle", 32'h0, 32'(irq));
		ushd_line_model_i.send(8'h3c, 1'b0);
		repeat (2) @(posedge clk);
		check("irq raised", 32'h1, 32'(irq));
		rd_chk("int status", ist_a, 32'h1);
		bus(1'b1, ien_a, 32'h0);
		check("irq masked", 32'h0, 32'(irq));
		bus(1'b1, ien_a, 32'h1);
		check("irq unmasked", 32'h1, 32'(irq));
		bus(1'b1, icl_a, 32'h1);
		check("irq cleared", 32'h0, 32'(irq));
		rd_chk("unmapped", 32'h50001200, 32'h0);
	endtask
	// A byte offered while the clock enable is low must leave the buffer untouched
	task automatic t_ce();
		ce <= 1'b0;
		ushd_line_model_i.send(8'h66, 1'b0);
		ce <= 1'b1;
		rd_chk("frozen status", ls_a, 32'h21);
		rd_chk("frozen byte", sh13, 32'h3c);
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Guards against a hang outside the bus waits
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		addr = '0;
		rd = 1'b0;
		wr = 1'b0;
		wdata = '0;
		stall = 1'b0;
		error_cnt = 0;
		checks_done = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_rx_plain();
		t_rx_fifo();
		t_tx_fifo();
		t_tx_plain();
		t_irq();
		t_ce();
		report_and_stop();
	end
endmodule
